// File: hdl/mpa_axis.sv
/*
 Modulo position axis: folds actual, command and captured positions into
 the configured range and feeds software limits, programmable limit
 switches, threshold outputs and absolute target checking.
 Assumes all inputs are synchronous to clk; the feedback device raises
 fb_valid once its multiturn position is on actual_position.
*/
// Operation
// - Modulo enable gates folding and switches consumers to folded values.
// - Smaller range bound is start, larger is end, in either order.
// - Actual and command positions are reported folded when enabled.
// - Capture engine 0 and 1 positions are reported folded when enabled.
// - Folded actual position beyond a software limit stops motion.
// - Software limit outside the modulo range never restricts motion.
// - Limit switch flag true while folded position is inside its window.
// - Limit switch window outside modulo range never becomes active.
// - Output mode 5 asserts above threshold, mode 6 below threshold.
// - Threshold outside range leaves output constantly on or off.
// - Absolute targets are folded into range when enabled before they are passed on.
// - Absolute target outside modulo range raises a warning.
// - After power-up load multiturn position and recompute folded position.
// - Restart is exact only if range divides multiturn span evenly.
// - Position reaching range end rolls over to range start.
`timescale 1ns/100ps
`default_nettype none
module mpa_axis #(
    parameter int NPLS = 4,
    parameter int NDOUT = 2,
    parameter logic [mpa_pkg::MPA_POS_W-1:0] MT_SPAN = mpa_pkg::MPA_MT_SPAN_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic modulo_enable,
    input wire logic signed [mpa_pkg::MPA_POS_W-1:0] range_bound_a,
    input wire logic signed [mpa_pkg::MPA_POS_W-1:0] range_bound_b,
    input wire logic fb_valid,
    input wire logic signed [mpa_pkg::MPA_POS_W-1:0] actual_position,
    input wire logic signed [mpa_pkg::MPA_POS_W-1:0] command_position,
    input wire logic signed [mpa_pkg::MPA_POS_W-1:0] capture_zero_position,
    input wire logic signed [mpa_pkg::MPA_POS_W-1:0] capture_one_position,
    input wire logic signed [mpa_pkg::MPA_POS_W-1:0] swlim_pos,
    input wire logic signed [mpa_pkg::MPA_POS_W-1:0] swlim_neg,
    input wire logic [NPLS*mpa_pkg::MPA_POS_W-1:0] pls_low,
    input wire logic [NPLS*mpa_pkg::MPA_POS_W-1:0] pls_high,
    input wire logic [NDOUT*mpa_pkg::MPA_MODE_W-1:0] dout_mode,
    input wire logic [NDOUT*mpa_pkg::MPA_POS_W-1:0] dout_thresh,
    input wire logic task_start,
    input wire logic signed [mpa_pkg::MPA_POS_W-1:0] task_target,
    input wire logic warn_clear,
    output logic signed [mpa_pkg::MPA_POS_W-1:0] actual_out,
    output logic signed [mpa_pkg::MPA_POS_W-1:0] command_out,
    output logic signed [mpa_pkg::MPA_POS_W-1:0] capture_zero_out,
    output logic signed [mpa_pkg::MPA_POS_W-1:0] capture_one_out,
    output logic signed [mpa_pkg::MPA_POS_W-1:0] task_target_out,
    output logic task_go,
    output logic motion_stop,
    output logic [NPLS-1:0] pls_active,
    output logic [NDOUT-1:0] dout_level,
    output logic target_warn,
    output logic position_ready,
    output logic restart_exact
);
    import mpa_pkg::*;

    localparam int W = MPA_POS_W;

    logic signed [W-1:0] rstart;
    logic signed [W-1:0] rend;
    logic signed [W-1:0] f_act, f_cmd, f_cap0, f_cap1, f_tgt;
    logic in_tgt;
    logic [W-1:0] span_u;

    mpa_state_t state_r, state_nxt;
    logic signed [W-1:0] act_r, act_nxt;
    logic signed [W-1:0] cmd_r, cmd_nxt;
    logic signed [W-1:0] cap0_r, cap0_nxt;
    logic signed [W-1:0] cap1_r, cap1_nxt;
    logic signed [W-1:0] tgt_r, tgt_nxt;
    logic go_r, go_nxt;
    logic stop_r, stop_nxt;
    logic [NPLS-1:0] pls_r, pls_nxt;
    logic [NDOUT-1:0] dout_r, dout_nxt;
    logic warn_r, warn_nxt;
    logic ready_r, ready_nxt;
    logic exact_r, exact_nxt;

    always_comb begin
        if (range_bound_a <= range_bound_b) begin
            rstart = range_bound_a;
            rend = range_bound_b;
        end else begin
            rstart = range_bound_b;
            rend = range_bound_a;
        end
        span_u = W'(rend - rstart);
    end

    mpa_fold #(.W(W)) u_fold_act (.enable(modulo_enable), .range_start(rstart),
        .range_end(rend), .raw(actual_position), .folded(f_act), .in_range());
    mpa_fold #(.W(W)) u_fold_cmd (.enable(modulo_enable), .range_start(rstart),
        .range_end(rend), .raw(command_position), .folded(f_cmd), .in_range());
    mpa_fold #(.W(W)) u_fold_cap0 (.enable(modulo_enable), .range_start(rstart),
        .range_end(rend), .raw(capture_zero_position), .folded(f_cap0), .in_range());
    mpa_fold #(.W(W)) u_fold_cap1 (.enable(modulo_enable), .range_start(rstart),
        .range_end(rend), .raw(capture_one_position), .folded(f_cap1), .in_range());
    mpa_fold #(.W(W)) u_fold_tgt (.enable(modulo_enable), .range_start(rstart),
        .range_end(rend), .raw(task_target), .folded(f_tgt), .in_range(in_tgt));

    always_comb begin
        logic signed [W-1:0] lo, hi, thr;
        logic [MPA_MODE_W-1:0] md;
        logic in_win;
        lo = '0;
        hi = '0;
        thr = '0;
        md = '0;
        in_win = 1'b0;
        state_nxt = state_r;
        act_nxt = act_r;
        cmd_nxt = cmd_r;
        cap0_nxt = cap0_r;
        cap1_nxt = cap1_r;
        tgt_nxt = tgt_r;
        go_nxt = 1'b0;
        stop_nxt = stop_r;
        pls_nxt = pls_r;
        dout_nxt = dout_r;
        warn_nxt = warn_r;
        ready_nxt = ready_r;
        // exact restart needs integer fit of range in multiturn span
        exact_nxt = (span_u != '0) && ((MT_SPAN % span_u) == '0);
        if (warn_clear) begin
            warn_nxt = 1'b0;
        end
        unique case (state_r)
            MPA_ST_LOAD: begin
                // wait for multiturn position, then fold it
                if (fb_valid) begin
                    act_nxt = f_act;
                    ready_nxt = 1'b1;
                    state_nxt = MPA_ST_RUN;
                end
            end
            MPA_ST_RUN: begin
                act_nxt = f_act;
                cmd_nxt = f_cmd;
                cap0_nxt = f_cap0;
                cap1_nxt = f_cap1;
                stop_nxt = 1'b0;
                if ((!modulo_enable || (swlim_pos >= rstart && swlim_pos < rend))
                    && f_act > swlim_pos) begin
                    stop_nxt = 1'b1;
                end
                if ((!modulo_enable || (swlim_neg >= rstart && swlim_neg < rend))
                    && f_act < swlim_neg) begin
                    stop_nxt = 1'b1;
                end
                for (int i = 0; i < NPLS; i++) begin
                    lo = pls_low[i*W +: W];
                    hi = pls_high[i*W +: W];
                    in_win = (f_act >= lo) && (f_act <= hi);
                    if (modulo_enable && (lo < rstart || hi >= rend)) begin
                        in_win = 1'b0;
                    end
                    pls_nxt[i] = in_win;
                end
                for (int j = 0; j < NDOUT; j++) begin
                    md = dout_mode[j*MPA_MODE_W +: MPA_MODE_W];
                    thr = dout_thresh[j*W +: W];
                    // out-of-range threshold gives a fixed level naturally
                    if (md == MPA_MODE_ABOVE) begin
                        dout_nxt[j] = f_act > thr;
                    end else if (md == MPA_MODE_BELOW) begin
                        dout_nxt[j] = f_act < thr;
                    end else begin
                        dout_nxt[j] = 1'b0;
                    end
                end
                if (task_start) begin
                    tgt_nxt = f_tgt;
                    go_nxt = 1'b1;
                    // warn on out-of-range target; set beats clear
                    if (modulo_enable && !in_tgt) begin
                        warn_nxt = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= MPA_ST_LOAD;
            act_r <= MPA_POS_RST;
            cmd_r <= MPA_POS_RST;
            cap0_r <= MPA_POS_RST;
            cap1_r <= MPA_POS_RST;
            tgt_r <= MPA_POS_RST;
            go_r <= MPA_FLAG_RST;
            stop_r <= MPA_FLAG_RST;
            pls_r <= '0;
            dout_r <= '0;
            warn_r <= MPA_FLAG_RST;
            ready_r <= MPA_FLAG_RST;
            exact_r <= MPA_FLAG_RST;
        end else begin
            state_r <= state_nxt;
            act_r <= act_nxt;
            cmd_r <= cmd_nxt;
            cap0_r <= cap0_nxt;
            cap1_r <= cap1_nxt;
            tgt_r <= tgt_nxt;
            go_r <= go_nxt;
            stop_r <= stop_nxt;
            pls_r <= pls_nxt;
            dout_r <= dout_nxt;
            warn_r <= warn_nxt;
            ready_r <= ready_nxt;
            exact_r <= exact_nxt;
        end
    end

    assign actual_out = act_r;
    assign command_out = cmd_r;
    assign capture_zero_out = cap0_r;
    assign capture_one_out = cap1_r;
    assign task_target_out = tgt_r;
    assign task_go = go_r;
    assign motion_stop = stop_r;
    assign pls_active = pls_r;
    assign dout_level = dout_r;
    assign target_warn = warn_r;
    assign position_ready = ready_r;
    assign restart_exact = exact_r;
endmodule
`default_nettype wire

// File: hdl/mpa_fold.sv
/*
 Combinational fold of one raw position into the modulo range, plus a flag
 that tells whether the raw value already lies inside the range.
 Assumes range_start <= range_end, ordered by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
module mpa_fold #(
    parameter int W = 32
) (
    input wire logic enable,
    input wire logic signed [W-1:0] range_start,
    input wire logic signed [W-1:0] range_end,
    input wire logic signed [W-1:0] raw,
    output logic signed [W-1:0] folded,
    output logic in_range
);
    logic signed [W+1:0] span;
    logic signed [W+1:0] diff;
    logic signed [W+1:0] rem;

    always_comb begin
        span = {{2{range_end[W-1]}}, range_end} - {{2{range_start[W-1]}}, range_start};
        diff = {{2{raw[W-1]}}, raw} - {{2{range_start[W-1]}}, range_start};
        rem = '0;
        in_range = (raw >= range_start) && (raw < range_end);
        folded = raw;
        if (enable && span != '0) begin
            rem = diff % span;
            if (rem < 0) begin
                rem = rem + span;
            end
            folded = W'(range_start + W'(rem));
        end
    end
endmodule
`default_nettype wire

// File: hdl/mpa_pkg.sv
/*
 Shared constants for the modulo position axis: widths, output modes,
 reset values and the start-up state type.
 Assumes positions are signed two's complement counts.
*/
package mpa_pkg;
    localparam int MPA_POS_W = 32;
    localparam int MPA_MODE_W = 3;
    localparam logic [MPA_MODE_W-1:0] MPA_MODE_ABOVE = 3'h5;
    localparam logic [MPA_MODE_W-1:0] MPA_MODE_BELOW = 3'h6;
    localparam logic [MPA_POS_W-1:0] MPA_POS_RST = 32'h00000000;
    localparam logic MPA_FLAG_RST = 1'h0;
    // Plain default multiturn span; override per encoder
    localparam logic [MPA_POS_W-1:0] MPA_MT_SPAN_DEF = 32'h40000000;

    typedef enum logic [1:0] {
        MPA_ST_LOAD = 2'b01,
        MPA_ST_RUN = 2'b10
    } mpa_state_t;
endpackage

// File: test/mpa_axis_properties.sv
/* Port checks for mpa_axis.
 Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module mpa_axis_chk #(
    parameter logic [mpa_pkg::MPA_POS_W-1:0] MT_SPAN = mpa_pkg::MPA_MT_SPAN_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic modulo_enable,
    input wire logic fb_valid,
    input wire logic task_start,
    input wire logic warn_clear,
    input wire logic task_go,
    input wire logic target_warn,
    input wire logic position_ready,
    input wire logic restart_exact,
    input wire logic signed [31:0] range_bound_a,
    input wire logic signed [31:0] range_bound_b,
    input wire logic signed [31:0] actual_position,
    input wire logic signed [31:0] task_target,
    input wire logic signed [31:0] actual_out,
    input wire logic signed [31:0] command_out
);
    logic signed [31:0] lo, hi;
    logic on, exact;
    assign lo = range_bound_a < range_bound_b ? range_bound_a : range_bound_b;
    assign hi = range_bound_a < range_bound_b ? range_bound_b : range_bound_a;
    assign on = position_ready && modulo_enable && lo != hi;
    assign exact = lo != hi && MT_SPAN % 32'(hi - lo) == 0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_LOAD: assert property (!position_ready && fb_valid |=> position_ready)
        else $error("no start-up load");
    AST_RAW: assert property ($past(position_ready) && !$past(modulo_enable)
        |-> actual_out == $past(actual_position)) else $error("raw position altered");
    AST_ACT: assert property ($past(on) |-> actual_out >= $past(lo) && actual_out < $past(hi))
        else $error("actual not folded");
    AST_CMD: assert property ($past(on) |-> command_out >= $past(lo) && command_out < $past(hi))
        else $error("command not folded");
    AST_GO: assert property (task_go == ($past(task_start) && $past(position_ready)))
        else $error("task pulse wrong");
    AST_WSET: assert property (on && task_start && (task_target < lo || task_target >= hi)
        |=> target_warn) else $error("warning missing");
    AST_WHOLD: assert property (target_warn && !warn_clear |=> target_warn)
        else $error("warning dropped");
    AST_EXACT: assert property ($past(position_ready) |-> restart_exact == $past(exact))
        else $error("restart flag wrong");
    CP_GO: cover property (task_go);
    CP_WARN: cover property ($rose(target_warn));
    CP_EXACT: cover property (position_ready && restart_exact);
endmodule
bind mpa_axis mpa_axis_chk #(.MT_SPAN(MT_SPAN)) u_chk (.*);
`default_nettype wire

// File: test/mpa_enc_model.sv
/* Multiturn encoder: position wraps at SPAN, valid some cycles after reset.
 Assumes the axis samples on the rising edge of clk. */
`timescale 1ns/100ps
`default_nettype none
module mpa_enc_model #(
    parameter longint SPAN = 64'h1000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] lag,
    input wire logic signed [31:0] step,
    output logic fb_valid,
    output logic signed [31:0] position
);
    int cnt = 0;
    longint p;
    always @(posedge clk) begin
        cnt <= rst ? 0 : cnt + 1;
        fb_valid <= !rst && cnt > lag;
        p = (position + longint'(step)) % SPAN;
        position <= rst ? 32'h00000F00 : 32'(p < 0 ? p + SPAN : p);
    end
endmodule
`default_nettype wire

// File: test/tb_top.sv
/* Random bench for mpa_axis against a fold model.
 Assumes the encoder model drives the feedback side. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import mpa_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic modulo_enable = 1'b0;
    logic task_start = 1'b0;
    logic warn_clear = 1'b0;
    logic fb_valid, task_go, motion_stop, target_warn, position_ready, restart_exact;
    logic [0:0] pls_active, dout_level;
    logic [2:0] dout_mode = 3'h0;
    logic [7:0] lag = 8'h00;
    logic [31:0] pls_low, pls_high, dout_thresh;
    logic signed [31:0] range_bound_a = 32'h0, range_bound_b = 32'h0, step = 32'h0;
    logic signed [31:0] command_position = 32'h0, swlim_pos = 32'h0, swlim_neg = 32'h0;
    logic signed [31:0] task_target = 32'h0, actual_position, actual_out, command_out;
    logic signed [31:0] capture_zero_out, capture_one_out, task_target_out;
    logic signed [31:0] capture_zero_position, capture_one_position;
    int seed = 32'h32B2;
    int n_fail = 0;
    int samples_checked = 0;
    longint s, e;
    bit rdy, w_m;
    // Shared random streams keep the driver short
    assign capture_zero_position = command_position;
    assign capture_one_position = -command_position;
    assign pls_low = swlim_neg;
    assign pls_high = swlim_pos;
    assign dout_thresh = task_target;
    mpa_enc_model #(.SPAN(64'h1000)) enc (.clk(clk), .rst(rst), .lag(lag), .step(step),
        .fb_valid(fb_valid), .position(actual_position));
    mpa_axis #(.NPLS(1), .NDOUT(1), .MT_SPAN(32'h00001000)) dut (.*);
    initial forever #2 clk = ~clk;
    function automatic longint fold(longint x);
        longint r;
        if (!modulo_enable || s == e) return x;
        r = (x - s) % (e - s);
        return r < 0 ? e + r : s + r;
    endfunction
    function automatic bit inr(longint x);
        // Equal bounds give an empty range, as the design treats it
        return !modulo_enable || (x >= s && x < e);
    endfunction
    task automatic chk_w(string n, logic [31:0] x, logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic chk_b(string n, logic x, logic g);
        chk_w(n, {31'h0, x}, {31'h0, g});
    endtask
    task automatic tick();
        longint f, w, th;
        logic [31:0] ea, ec, e1, et;
        logic go, st, pa, dl, ex;
        logic [1:0] sw;
        @(posedge clk);
        s = range_bound_a < range_bound_b ? range_bound_a : range_bound_b;
        e = range_bound_a < range_bound_b ? range_bound_b : range_bound_a;
        f = fold(actual_position);
        th = $signed(dout_thresh);
        ea = 32'(f);
        ec = 32'(fold(command_position));
        e1 = 32'(fold(capture_one_position));
        et = 32'(fold(task_target));
        go = task_start;
        st = (inr(swlim_pos) && f > swlim_pos) || (inr(swlim_neg) && f < swlim_neg);
        pa = f >= swlim_neg && f <= swlim_pos && inr(swlim_neg) && inr(swlim_pos);
        dl = dout_mode == MPA_MODE_ABOVE ? f > th : dout_mode == MPA_MODE_BELOW && f < th;
        ex = s != e && 4096 % (e - s) == 0;
        if (!rdy) begin
            {ec, e1, go, st, pa, dl} = '0;
            ea = fb_valid ? ea : 32'h0;
        end
        w_m = (go && modulo_enable && !inr(task_target)) || (!warn_clear && w_m);
        rdy = rdy || fb_valid;
        sw = 2'($random(seed));
        w = sw[0] ? 1024 : longint'($unsigned($random(seed))) % 5000;
        s = $random(seed) % 3000;
        e = s + w;
        range_bound_a <= 32'(sw[1] ? s : e);
        range_bound_b <= 32'(sw[1] ? e : s);
        modulo_enable <= ($random(seed) & 7) != 0;
        command_position <= $random(seed);
        swlim_pos <= $random(seed) % 6000;
        swlim_neg <= $random(seed) % 6000;
        dout_mode <= 3'($random(seed));
        task_start <= ($random(seed) & 3) == 0;
        task_target <= $random(seed) % 6000;
        warn_clear <= ($random(seed) & 7) == 0;
        step <= $random(seed) % 700;
        @(negedge clk);
        chk_w("actual_out", ea, actual_out);
        chk_w("command_out", ec, command_out);
        chk_w("capture_zero_out", ec, capture_zero_out);
        chk_w("capture_one_out", e1, capture_one_out);
        if (go) chk_w("task_target_out", et, task_target_out);
        chk_b("task_go", go, task_go);
        chk_b("target_warn", w_m, target_warn);
        chk_b("motion_stop", st, motion_stop);
        chk_b("pls_active", pa, pls_active[0]);
        chk_b("dout_level", dl, dout_level[0]);
        chk_b("position_ready", rdy, position_ready);
        if (rdy) chk_b("restart_exact", ex, restart_exact);
    endtask
    task automatic results();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic run(logic [7:0] l);
        @(posedge clk);
        lag <= l;
        rst <= 1'b1;
        repeat (7) @(posedge clk);
        rst <= 1'b0;
        rdy = 0;
        w_m = 0;
        for (int k = 0; k < 100 && !rdy; k++) tick();
        if (!rdy) begin
            n_fail++;
            results();
        end
        repeat (4000) tick();
    endtask
    initial begin
        run(8'h00);
        run(8'h28);
        results();
    end
endmodule
`default_nettype wire
